// File: verilog/fifo_flags_pkg.sv
// Purpose: Shared constants for the serial FIFO status-flag block.
// Assumes: Byte-granular FIFO occupancy counts, 8-byte FIFOs.
// Notes:   Register map offsets here are word indices on a plain port.
package fifo_flags_pkg;
    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [3:0] OFF_STATUS  = 4'h0;  // Flag status, read-only.
    localparam logic [3:0] OFF_CONTROL = 4'h1;  // Mode and threshold controls.
    localparam logic [3:0] OFF_IRQ_ST  = 4'h2;  // Sticky event bits, write one to clear.
    localparam logic [3:0] OFF_IRQ_MSK = 4'h3;  // Event mask.
    localparam logic [3:0] OFF_TX_CNT  = 4'h4;  // Transmit occupancy, read-only.
    localparam logic [3:0] OFF_RX_CNT  = 4'h5;  // Receive occupancy, read-only.

    // ==========================================================
    // Status field positions
    // ==========================================================
    localparam int ST_RX_EMPTY = 0;
    localparam int ST_TX_FULL  = 1;
    localparam int ST_TX_NEAR  = 2;
    localparam int ST_RX_NEAR  = 3;

    // ==========================================================
    // Control field positions
    // ==========================================================
    localparam int CT_SYS_EN   = 0;
    localparam int CT_FIFO_EN  = 1;
    localparam int CT_WIDE     = 2;
    localparam int CT_RX_MARK  = 3;
    localparam int CT_TX_MARK  = 4;
    localparam int CT_DMA_TX   = 5;
    localparam int CT_DMA_RX   = 6;

    // ==========================================================
    // Reset values and sizes
    // ==========================================================
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] MASK_RST    = 8'h00;
    localparam logic [3:0] FIFO_BYTES  = 4'h8;  // Depth of each FIFO in bytes.

    // ==========================================================
    // Thresholds in bytes (one 16-bit word counts as two bytes)
    // ==========================================================
    localparam logic [3:0] RX_ABOVE_M0_B = 4'h6;  // More than six bytes.
    localparam logic [3:0] RX_ABOVE_M1_B = 4'h4;  // More than four bytes.
    localparam logic [3:0] TX_UPTO_M0_B  = 4'h2;  // At most two bytes.
    localparam logic [3:0] TX_UPTO_M1_B  = 4'h4;  // At most four bytes.
endpackage

// File: verilog/spi_fifo_status_flags.sv
// Purpose: Status flags and DMA requests derived from serial FIFO occupancy.
// Assumes: FIFO storage lives elsewhere and reports occupancy in bytes.
// Notes:   Registers reached over a plain address and strobe port.
//
// Notes on behaviour
// - Mark zero: rx nearly full above three words
// - Mark one: rx nearly full above two words
// - Rx nearly full meaningless without FIFO mode
// - Mark zero: tx nearly empty at one word
// - Mark one: tx nearly empty at two words
// - Power-on clears tx near-empty and rx empty
// - Config change resets status, flushes both FIFOs
// - After flush, flags follow FIFO mode enable
// - Tx full exactly at eight bytes
// - Tx DMA request is inverted tx full
// - Rx DMA request is inverted rx empty
`timescale 1ns/1ps
module spi_fifo_status_flags
    import fifo_flags_pkg::*;
(
    input  wire logic       sys_clk_in,     // Peripheral clock, 10 MHz.
    input  wire logic       reset_in,       // Power-on reset, asynchronous, active high.
    input  wire logic [3:0] addr_in,        // Register index.
    input  wire logic [7:0] wdata_in,       // Write data.
    input  wire logic       wr_in,          // Write strobe.
    input  wire logic       rd_in,          // Read strobe.
    input  wire logic [3:0] tx_count_in,    // Transmit FIFO occupancy in bytes.
    input  wire logic [3:0] rx_count_in,    // Receive FIFO occupancy in bytes.
    output logic [7:0]      rdata_out,      // Read data, one cycle after the strobe.
    output logic            fifo_flush_out, // One-cycle pulse emptying both FIFOs.
    output logic            tx_dma_req_out, // Transmit DMA request.
    output logic            rx_dma_req_out, // Receive DMA request.
    output logic            irq_out         // Level interrupt.
);
    // ==========================================================
    // Declarations
    // ==========================================================
    logic [7:0] control_ff;        // Control register.
    logic [7:0] mask_ff;           // Interrupt mask register.
    logic [7:0] irq_st_ff;         // Sticky event bits.
    logic [3:0] status_ff;         // Flag register.
    logic [3:0] nxt_status;        // Next flag values.
    logic [3:0] status_prev_ff;    // Flags one cycle ago, for rising edges.
    logic       flush_hold_ff;     // Flags held at reset values this cycle.
    logic [7:0] nxt_control;       // Control after a write.
    logic       cfg_change;        // A configuration bit changes this write.
    logic       fifo_on;           // FIFO mode active.
    logic       wide;              // 16-bit word width.

    assign fifo_on = control_ff[CT_FIFO_EN];
    assign wide    = control_ff[CT_WIDE];

    // Selects the mark-one or mark-zero byte threshold; both widths share byte units.
    function automatic logic [3:0] thr_bytes(input logic mark, input logic [3:0] m0, input logic [3:0] m1);
        thr_bytes = mark ? m1 : m0;
    endfunction

    // ==========================================================
    // Control writes and change detection
    // ==========================================================
    // The control value a write would produce; used to spot config changes.
    always_comb begin
        nxt_control = control_ff;
        if (wr_in && addr_in == OFF_CONTROL) begin
            nxt_control = wdata_in;
        end
    end

    // Width, FIFO mode or system enable flipping triggers a reset of flags.
    assign cfg_change = (nxt_control[CT_WIDE]    != control_ff[CT_WIDE])
                     || (nxt_control[CT_FIFO_EN] != control_ff[CT_FIFO_EN])
                     || (nxt_control[CT_SYS_EN]  != control_ff[CT_SYS_EN]);

    // Control register storage.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            control_ff <= CONTROL_RST;
        end else begin
            control_ff <= nxt_control;
        end
    end

    // Mask register storage.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mask_ff <= MASK_RST;
        end else if (wr_in && addr_in == OFF_IRQ_MSK) begin
            mask_ff <= wdata_in;
        end
    end

    // Flush pulse to the FIFO storage; flags are held for that cycle so a
    // stale occupancy count from before the flush is never reported.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            fifo_flush_out <= 1'b0;
            flush_hold_ff  <= 1'b0;
        end else begin
            fifo_flush_out <= cfg_change;
            flush_hold_ff  <= cfg_change;
        end
    end

    // ==========================================================
    // Flag derivation
    // ==========================================================
    // Flags follow occupancy and marks every clock; software cannot write them.
    // Thresholds are kept in bytes for both word widths, since one 16-bit word
    // always occupies two bytes of FIFO storage. The width bit therefore only
    // matters through the flush that its change triggers.
    // The trade-off: status lags occupancy by one clock, which keeps the read
    // path and the DMA requests free of the occupancy adder's timing.
    always_comb begin
        nxt_status = 4'h0;
        if (flush_hold_ff) begin
            // Empty FIFOs: near-empty and empty read one only in FIFO mode.
            nxt_status[ST_TX_NEAR]  = fifo_on;
            nxt_status[ST_RX_EMPTY] = fifo_on;
        end else if (fifo_on) begin
            // Outside FIFO mode every flag stays zero and carries no meaning.
            nxt_status[ST_RX_NEAR]  = rx_count_in > thr_bytes(control_ff[CT_RX_MARK], RX_ABOVE_M0_B,
                                                               RX_ABOVE_M1_B);
            nxt_status[ST_TX_NEAR]  = tx_count_in <= thr_bytes(control_ff[CT_TX_MARK], TX_UPTO_M0_B,
                                                                TX_UPTO_M1_B);
            nxt_status[ST_TX_FULL]  = tx_count_in >= FIFO_BYTES;
            nxt_status[ST_RX_EMPTY] = rx_count_in == 4'h0;
        end
    end

    // Flag register; cleared at power-on.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            status_ff      <= 4'h0;
            status_prev_ff <= 4'h0;
        end else begin
            status_ff      <= nxt_status;
            status_prev_ff <= status_ff;
        end
    end

    // ==========================================================
    // DMA requests
    // ==========================================================
    // Requests need FIFO mode plus the matching DMA enable, and stay low in the cycle after a flush pulse.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_dma_req_out <= 1'b0;
            rx_dma_req_out <= 1'b0;
        end else begin
            tx_dma_req_out <= fifo_on && control_ff[CT_DMA_TX] && !nxt_status[ST_TX_FULL]
                              && !flush_hold_ff;
            rx_dma_req_out <= fifo_on && control_ff[CT_DMA_RX] && !nxt_status[ST_RX_EMPTY]
                              && !flush_hold_ff;
        end
    end

    // ==========================================================
    // Interrupts
    // ==========================================================
    // Rising flags set sticky bits; a write of one clears, but a new event wins.
    // Letting the set win means an edge that lands on the clearing write is
    // never lost; software simply sees the bit again on its next read.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_st_ff <= 8'h00;
        end else begin
            irq_st_ff <= (irq_st_ff & ~((wr_in && addr_in == OFF_IRQ_ST) ? wdata_in : 8'h00))
                         | {4'h0, status_ff & ~status_prev_ff};
        end
    end

    // Interrupt output registered so it comes straight from a flip-flop.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_st_ff & mask_ff);
        end
    end

    // ==========================================================
    // Register read port
    // ==========================================================
    // Read data valid only the cycle after the strobe; zero otherwise.
    // Returning zero between reads keeps stale flags off the shared read bus.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                OFF_STATUS:  rdata_out <= {4'h0, status_ff};
                OFF_CONTROL: rdata_out <= control_ff;
                OFF_IRQ_ST:  rdata_out <= irq_st_ff;
                OFF_IRQ_MSK: rdata_out <= mask_ff;
                OFF_TX_CNT:  rdata_out <= {4'h0, tx_count_in};
                OFF_RX_CNT:  rdata_out <= {4'h0, rx_count_in};
                default:     rdata_out <= 8'h00; // Unmapped reads as zero.
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    // The occupancy flag properties look one clock ahead, because the flag register
    // captures the occupancy that stood at the edge before.

    // Mark zero: more than six bytes held raises the receive nearly-full flag.
    // The flush cycle is excluded, since the presets take over there.
    property p_rx_near_m0;
        @(posedge sys_clk_in) disable iff (reset_in)
        (fifo_on && !flush_hold_ff && !control_ff[CT_RX_MARK])
            |=> status_ff[ST_RX_NEAR] == ($past(rx_count_in) > RX_ABOVE_M0_B);
    endproperty
    a_rx_near_m0: assert property (p_rx_near_m0)
        else $error("rx nearly full wrong at mark 0");

    // Mark one: more than four bytes held raises the receive nearly-full flag.
    // This is the earlier warning, for a reader that answers slowly.
    property p_rx_near_m1;
        @(posedge sys_clk_in) disable iff (reset_in)
        (fifo_on && !flush_hold_ff && control_ff[CT_RX_MARK])
            |=> status_ff[ST_RX_NEAR] == ($past(rx_count_in) > RX_ABOVE_M1_B);
    endproperty
    a_rx_near_m1: assert property (p_rx_near_m1)
        else $error("rx nearly full wrong at mark 1");

    // Outside FIFO mode every flag reads zero, so nothing meaningless leaks.
    // A reader that forgets to check the mode still sees a quiet register.
    property p_off_zero;
        @(posedge sys_clk_in) disable iff (reset_in)
        (!fifo_on && !flush_hold_ff)
            |=> status_ff == 4'h0;
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("flags set outside FIFO mode");

    // Mark zero: two bytes or fewer left raises the transmit nearly-empty flag.
    // The comparison is inclusive, unlike the receive side.
    property p_tx_near_m0;
        @(posedge sys_clk_in) disable iff (reset_in)
        (fifo_on && !flush_hold_ff && !control_ff[CT_TX_MARK])
            |=> status_ff[ST_TX_NEAR] == ($past(tx_count_in) <= TX_UPTO_M0_B);
    endproperty
    a_tx_near_m0: assert property (p_tx_near_m0)
        else $error("tx nearly empty wrong at mark 0");

    // Mark one: four bytes or fewer left raises the transmit nearly-empty flag.
    // This gives a writer more slack before the shifter runs dry.
    property p_tx_near_m1;
        @(posedge sys_clk_in) disable iff (reset_in)
        (fifo_on && !flush_hold_ff && control_ff[CT_TX_MARK])
            |=> status_ff[ST_TX_NEAR] == ($past(tx_count_in) <= TX_UPTO_M1_B);
    endproperty
    a_tx_near_m1: assert property (p_tx_near_m1)
        else $error("tx nearly empty wrong at mark 1");

    // A configuration change pulses the flush, then presets the two flags
    // to the FIFO mode bit that stood during the flush cycle.
    property p_flush;
        @(posedge sys_clk_in) disable iff (reset_in)
        cfg_change |=> fifo_flush_out ##1 (status_ff[ST_TX_NEAR] == $past(fifo_on)
                                           && status_ff[ST_RX_EMPTY] == $past(fifo_on));
    endproperty
    a_flush: assert property (p_flush)
        else $error("config change did not reset flags");

    // Without a configuration change the FIFOs are never flushed.
    // A spurious flush would silently drop queued data.
    property p_flush_quiet;
        @(posedge sys_clk_in) disable iff (reset_in)
        !cfg_change |=> !fifo_flush_out;
    endproperty
    a_flush_quiet: assert property (p_flush_quiet)
        else $error("flush without a configuration change");

    // Transmit full stands exactly while all eight bytes are held.
    // The storage never reports more than its depth.
    property p_tx_full;
        @(posedge sys_clk_in) disable iff (reset_in)
        (fifo_on && !flush_hold_ff)
            |=> status_ff[ST_TX_FULL] == ($past(tx_count_in) == FIFO_BYTES);
    endproperty
    a_tx_full: assert property (p_tx_full)
        else $error("tx full wrong");

    // Receive empty follows a zero occupancy in FIFO mode.
    // The DMA drain depends on this flag, so it is checked on its own.
    property p_rx_empty;
        @(posedge sys_clk_in) disable iff (reset_in)
        (fifo_on && !flush_hold_ff)
            |=> status_ff[ST_RX_EMPTY] == ($past(rx_count_in) == 4'h0);
    endproperty
    a_rx_empty: assert property (p_rx_empty)
        else $error("rx empty wrong");

    // The transmit request mirrors the inverted full flag of the same cycle.
    // Both come from one next-value, so they can never disagree by a clock.
    property p_tx_dma;
        @(posedge sys_clk_in) disable iff (reset_in)
        (fifo_on && control_ff[CT_DMA_TX] && !flush_hold_ff)
            |=> tx_dma_req_out == !status_ff[ST_TX_FULL];
    endproperty
    a_tx_dma: assert property (p_tx_dma)
        else $error("tx DMA not inverse of full");

    // The receive request mirrors the inverted empty flag of the same cycle.
    // It drops one clock after the last byte leaves, so the engine guards against reading air.
    property p_rx_dma;
        @(posedge sys_clk_in) disable iff (reset_in)
        (fifo_on && control_ff[CT_DMA_RX] && !flush_hold_ff)
            |=> rx_dma_req_out == !status_ff[ST_RX_EMPTY];
    endproperty
    a_rx_dma: assert property (p_rx_dma)
        else $error("rx DMA not inverse of empty");

    // A write aimed at the flag register changes nothing; the flags keep
    // following occupancy, so a written zero cannot hide an empty FIFO.
    property p_ro;
        @(posedge sys_clk_in) disable iff (reset_in)
        (wr_in && addr_in == OFF_STATUS && fifo_on && !flush_hold_ff)
            |=> status_ff[ST_RX_EMPTY] == ($past(rx_count_in) == 4'h0);
    endproperty
    a_ro: assert property (p_ro)
        else $error("status changed by write");

    // At the first edge after power-on reset both preset flags read zero.
    // No disable clause here, since the check sits on the release itself.
    property p_por;
        @(posedge sys_clk_in)
        $fell(reset_in) |-> (status_ff[ST_TX_NEAR] == 1'b0 && status_ff[ST_RX_EMPTY] == 1'b0);
    endproperty
    a_por: assert property (p_por)
        else $error("flags not cleared at power-on");

    // Coverage of the main scenarios: flush, full, interrupt, wide mode, drain.
    c_flush:  cover property (@(posedge sys_clk_in) disable iff (reset_in) fifo_flush_out);
    c_full:   cover property (@(posedge sys_clk_in) disable iff (reset_in) status_ff[ST_TX_FULL]);
    c_irq:    cover property (@(posedge sys_clk_in) disable iff (reset_in) irq_out);
    c_wide:   cover property (@(posedge sys_clk_in) disable iff (reset_in) wide && status_ff[ST_RX_NEAR]);
    c_rx_dma: cover property (@(posedge sys_clk_in) disable iff (reset_in) rx_dma_req_out);
endmodule // spi_fifo_status_flags

// File: sim/fifo_occupancy_model.sv
// Purpose: Far-side model holding both FIFO occupancy counts and a DMA engine.
// Assumes: Counts in bytes, 0 to 8; one byte moves per clock while a request stands.
// Notes:   The bench loads counts directly, or lets the DMA engine move bytes.
`timescale 1ns/1ps
module fifo_occupancy_model (
    input  wire logic       sys_clk_in,    // Peripheral clock.
    input  wire logic       reset_in,      // Power-on reset, active high.
    input  wire logic       load_in,       // Load both counts from the bench.
    input  wire logic [3:0] tx_load_in,    // Transmit count to load.
    input  wire logic [3:0] rx_load_in,    // Receive count to load.
    input  wire logic       dma_run_in,    // Let the DMA engine answer requests.
    input  wire logic       tx_dma_req_in, // Transmit request from the block.
    input  wire logic       rx_dma_req_in, // Receive request from the block.
    input  wire logic       flush_in,      // Flush pulse from the block.
    output logic [3:0]      tx_count_out,  // Transmit occupancy.
    output logic [3:0]      rx_count_out   // Receive occupancy.
);
    // ==========================================================
    // Occupancy
    // ==========================================================
    // The fill guard stops an overshoot, since a request lags the count by a cycle.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_count_out <= 4'h0;
            rx_count_out <= 4'h0;
        end else if (flush_in) begin
            tx_count_out <= 4'h0;
            rx_count_out <= 4'h0;
        end else if (load_in) begin
            tx_count_out <= tx_load_in;
            rx_count_out <= rx_load_in;
        end else if (dma_run_in) begin
            if (tx_dma_req_in && tx_count_out < 4'h8) begin
                tx_count_out <= tx_count_out + 4'h1;
            end
            if (rx_dma_req_in && rx_count_out != 4'h0) begin
                rx_count_out <= rx_count_out - 4'h1;
            end
        end
    end
endmodule // fifo_occupancy_model

// File: sim/spi_fifo_status_flags_tb.sv
// Purpose: Self-checking bench for the FIFO status-flag block.
// Assumes: Reads are noted in a queue and compared when the data stand.
// Notes:   Transmit flags are judged with FIFO mode on, and as zero with it off.
`timescale 1ns/1ps
module spi_fifo_status_flags_tb;
    import fifo_flags_pkg::*;
    logic       sys_clk_in = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, load = 1'b0, run = 1'b0;
    logic [3:0] addr_in = 4'h0, tx_ld = 4'h0, rx_ld = 4'h0, tx_count, rx_count;
    logic [7:0] wdata_in = 8'h00, rdata_out, ctl;
    logic       flush, tx_req, rx_req, irq_out, rd_pend = 1'b0;
    logic [7:0] exp_q[$];                 // Expected read data, oldest first.
    logic [7:0] cfgs[5] = '{8'h63, 8'h67, 8'h65, 8'h64, 8'h63};
    logic [7:0] cexp[5] = '{8'h05, 8'h05, 8'h00, 8'h00, 8'h05};
    integer     seed = 32'hf0918476, fail_count = 0, n_checks = 0, m, i;
    logic [3:0] t, r;
    always #50 sys_clk_in = ~sys_clk_in;  // 10 MHz.
    spi_fifo_status_flags DUT (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .tx_count_in(tx_count), .rx_count_in(rx_count),
        .rdata_out(rdata_out), .fifo_flush_out(flush), .tx_dma_req_out(tx_req), .rx_dma_req_out(rx_req),
        .irq_out(irq_out));
    fifo_occupancy_model far (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .load_in(load),
        .tx_load_in(tx_ld), .rx_load_in(rx_ld), .dma_run_in(run), .tx_dma_req_in(tx_req),
        .rx_dma_req_in(rx_req), .flush_in(flush), .tx_count_out(tx_count), .rx_count_out(rx_count));
    // ==========================================================
    // Checking and closing
    // ==========================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe, so look mid-cycle there.
    always @(negedge sys_clk_in) begin
        if (rd_pend) check(rdata_out, exp_q.pop_front());
        rd_pend = rd_in;
    end
    // A hang is cut short well past the fewer than a thousand cycles the run needs.
    initial begin
        #(100 * 20000);
        fail_count++;
        end_sim();
    end
    // ==========================================================
    // Bus and stimulus tasks
    // ==========================================================
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        wr_in <= w; rd_in <= !w; addr_in <= a; wdata_in <= d;
        @(posedge sys_clk_in);
        wr_in <= 1'b0; rd_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask
    // Counts load one edge later and flags follow one edge after that.
    task automatic set_counts(input logic [3:0] tx, input logic [3:0] rx);
        @(posedge sys_clk_in);
        load <= 1'b1; tx_ld <= tx; rx_ld <= rx;
        @(posedge sys_clk_in);
        load <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
    endtask
    function automatic logic [7:0] flags(input logic [3:0] tx, rx, input logic rxm, txm);
        flags = 8'h00;
        flags[ST_RX_EMPTY] = (rx == 4'h0);
        flags[ST_TX_FULL]  = (tx >= 4'h8);
        flags[ST_TX_NEAR]  = (tx <= (txm ? 4'h4 : 4'h2));
        flags[ST_RX_NEAR]  = (rx > (rxm ? 4'h4 : 4'h6));
    endfunction
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (20) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        rd(OFF_STATUS, 8'h00);
        rd(OFF_CONTROL, CONTROL_RST);
        rd(OFF_IRQ_MSK, MASK_RST);
        // Each enable or width change flushes both FIFOs and presets the flags.
        for (m = 0; m < 5; m++) begin
            set_counts(4'h5, 4'h3);
            bus(1'b1, OFF_CONTROL, cfgs[m]);
            repeat (3) @(posedge sys_clk_in);
            rd(OFF_TX_CNT, 8'h00);
            rd(OFF_RX_CNT, 8'h00);
            rd(OFF_STATUS, cexp[m]);
        end
        // Every threshold select pair over a sweep, then random counts.
        for (m = 0; m < 4; m++) begin
            ctl = 8'h63 | (m[1:0] << 3);            // marks from m; this sweep judges the flags in FIFO mode only
            bus(1'b1, OFF_CONTROL, ctl);
            for (i = 0; i < 17; i++) begin
                t = (i < 9) ? i[3:0] : 4'($unsigned($random(seed)) % 9);
                r = (i < 9) ? 4'(8 - i) : 4'($unsigned($random(seed)) % 9);
                set_counts(t, r);
                rd(OFF_STATUS, flags(t, r, m[0], m[1]));
                @(negedge sys_clk_in);
                check({7'h00, tx_req}, {7'h00, t < 4'h8});
                check({7'h00, rx_req}, {7'h00, r != 4'h0});
            end
        end
        bus(1'b1, OFF_STATUS, 8'hFF);
        rd(OFF_STATUS, flags(t, r, 1'b1, 1'b1));
        rd(4'hF, 8'h00);
        // Interrupt: raise the receive near-full event, mask it, clear it.
        bus(1'b1, OFF_CONTROL, 8'h63);
        set_counts(4'h4, 4'h0);
        bus(1'b1, OFF_IRQ_ST, 8'hFF);
        bus(1'b1, OFF_IRQ_MSK, 8'h08);
        set_counts(4'h4, 4'h8);
        rd(OFF_IRQ_ST, 8'h08);
        @(negedge sys_clk_in);
        check({7'h00, irq_out}, 8'h01);
        bus(1'b1, OFF_IRQ_MSK, 8'h00);
        repeat (2) @(negedge sys_clk_in);
        check({7'h00, irq_out}, 8'h00);
        bus(1'b1, OFF_IRQ_MSK, 8'h08);
        bus(1'b1, OFF_IRQ_ST, 8'h08);
        repeat (2) @(negedge sys_clk_in);
        check({7'h00, irq_out}, 8'h00);
        // DMA engine fills transmit and drains receive until the requests drop.
        set_counts(4'h1, 4'h6);
        @(posedge sys_clk_in);
        run <= 1'b1;
        repeat (30) @(posedge sys_clk_in);
        rd(OFF_TX_CNT, 8'h08);
        rd(OFF_RX_CNT, 8'h00);
        rd(OFF_STATUS, 8'h03);
        @(negedge sys_clk_in);
        check({6'h00, tx_req, rx_req}, 8'h00);
        repeat (3) @(posedge sys_clk_in);
        end_sim();
    end
endmodule // spi_fifo_status_flags_tb
